// ==== rtl/fpsc_pkg.sv ====
// Purpose: Shared constants for the fabric performance state controller
// Assumes: 50 MHz clock, registers on classic Wishbone
// Notes: Times kept in their own units, cycle counts derived and rounded up
package fpsc_pkg;
    localparam int CLK_NS = 20;
    localparam int CNT_W = 22;
    localparam int ADR_W = 8;

    localparam logic [7:0] OFF_CFG_LO = 8'h90;
    localparam logic [7:0] OFF_CFG_HI = 8'h94;
    localparam logic [7:0] OFF_CTL = 8'h98;

    localparam int B_CAP = 31;
    localparam int B_DIS = 30;
    localparam int B_FSEL = 29;
    localparam int B_FREQ = 28;
    localparam int B_LOCK = 20;
    localparam int B_IGN = 16;
    localparam int L_VID = 8;
    localparam int L_DIV = 0;
    localparam int L_HRES = 29;
    localparam int L_LRES = 26;
    localparam int L_ACT = 23;
    localparam int L_IDLE = 20;
    localparam int B_DMA = 4;
    localparam int B_THREN = 3;
    localparam int L_THR = 0;
    localparam int B_OVR = 31;
    localparam int B_CSEL = 30;
    localparam int B_LOWACT = 2;
    localparam int B_SEEN = 1;
    localparam int B_INFL = 0;

    localparam logic [31:0] CFG_HI_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_HI_MASK = 32'hFFF0_001F;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [6:0] DEF_HI_DIV = 7'h01;
    localparam logic [6:0] DEF_HI_VID = 7'h00;
    localparam logic [6:0] DEF_LO_DIV = 7'h02;
    localparam logic [6:0] DEF_LO_VID = 7'h00;

    localparam int T_120_NS = 120;
    localparam int T_25_US = 25;
    localparam int T_50_US = 50;
    localparam int T_100_US = 100;
    localparam int T_200_US = 200;
    localparam int T_500_US = 500;
    localparam int T_1_MS = 1;
    localparam int T_5_MS = 5;
    localparam int T_10_MS = 10;
    localparam int T_50_MS = 50;
    localparam int CYC_120NS = (T_120_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_25US = (T_25_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_50US = (T_50_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_100US = (T_100_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_200US = (T_200_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_500US = (T_500_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_1MS = (T_1_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_5MS = (T_5_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_10MS = (T_10_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_50MS = (T_50_MS * 1000000 + CLK_NS - 1) / CLK_NS;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_WAIT = 1'b1
    } fpsc_seq_t;
endpackage

// ==== rtl/fpsc_timer.sv ====
// Purpose: Up counter that reports when a condition has held long enough
// Assumes: run_i low clears the count
// Notes: Saturates at the limit so a held condition stays done
`timescale 1ns/1ps
module fpsc_timer #(
    parameter int CW = fpsc_pkg::CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic [CW-1:0] limit_i,
    output logic done_o
);
    logic [CW-1:0] cnt_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (ce_i) begin
            if (!run_i) begin
                cnt_ff <= '0;
            end else if (cnt_ff < limit_i) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign done_o = run_i && (cnt_ff >= limit_i);
endmodule

// ==== rtl/fpsc_apply.sv ====
// Purpose: Applies divisor and supply code and waits for the partner
// Assumes: Partner raises done_i once both are in effect
// Notes: One transition at a time; values frozen while waiting
`timescale 1ns/1ps
module fpsc_apply #(
    parameter logic [6:0] RST_DIV = fpsc_pkg::DEF_HI_DIV,
    parameter logic [6:0] RST_VID = fpsc_pkg::DEF_HI_VID
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [6:0] div_i,
    input wire logic [6:0] vid_i,
    input wire logic done_i,
    output logic [6:0] div_o,
    output logic [6:0] vid_o,
    output logic req_o,
    output logic busy_o,
    output logic fin_o
);
    fpsc_pkg::fpsc_seq_t st_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= fpsc_pkg::SEQ_IDLE;
            div_o <= RST_DIV;
            vid_o <= RST_VID;
        end else if (ce_i) begin
            case (st_ff)
                fpsc_pkg::SEQ_IDLE: begin
                    if (start_i) begin
                        st_ff <= fpsc_pkg::SEQ_WAIT;
                        div_o <= div_i;
                        vid_o <= vid_i;
                    end
                end
                default: begin
                    if (done_i) begin
                        st_ff <= fpsc_pkg::SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    assign busy_o = (st_ff == fpsc_pkg::SEQ_WAIT);
    assign req_o = busy_o;
    assign fin_o = busy_o && done_i && ce_i;

    AST_SEQ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_o && !done_i |=> busy_o && $stable(div_o) && $stable(vid_o))
        else $error("values moved while transition in flight");
    AST_SEQ_START: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !busy_o && start_i |=> busy_o && req_o)
        else $error("accepted start not shown in flight");
endmodule

// ==== rtl/fpsc_top.sv ====
// Purpose: Fabric performance state controller with Wishbone registers
// Assumes: Activity inputs synchronous to clk_i; partner acks changes
// Notes: State 0 is high performance, state 1 low performance
// Summary of operation
// - With hardware requests enabled the block requests state changes itself; never when disabled.
// - Setting the disable bit sends the fabric back to state 0.
// - Forced target select picks state 1 when set, state 0 when clear.
// - A forced request while idle starts at once, even with hardware requests disabled.
// - A forced request during a transition waits until that transition ends.
// - Lock bit is write-one-only and freezes disable, voltage code and divisor.
// - Ignore-GPU bit removes GPU activity from the decisions.
// - Low-state voltage code drives the regulator; new value used at next 0-to-1.
// - Low-state divisor sets the clock in state 1; changes apply immediately there.
// - Any core active for the selected time triggers state 1 to 0.
// - All cores idle for the selected time triggers state 0 to 1.
// - With the DMA bit set, DMA traffic blocks autonomous transitions.
// - Core threshold gates decisions when enabled; ignored when disabled.
// - Context follows current state unless override selects it explicitly.
// - Status bit shows the present state.
// - Sticky flag sets on entering state 1; software writes one to clear.
// - In-flight bit is high while a transition is in progress.
// - Capability bit is fixed per product.
`timescale 1ns/1ps
module fpsc_top #(
    parameter logic CAPABLE = 1'b1,
    parameter logic LOCK_RST = 1'b0,
    parameter logic [6:0] LO_VID_RST = fpsc_pkg::DEF_LO_VID,
    parameter logic [6:0] LO_DIV_RST = fpsc_pkg::DEF_LO_DIV,
    parameter logic [6:0] HI_VID = fpsc_pkg::DEF_HI_VID,
    parameter logic [6:0] HI_DIV = fpsc_pkg::DEF_HI_DIV,
    parameter int CW = fpsc_pkg::CNT_W,
    parameter int CYC_100US = fpsc_pkg::CYC_100US,
    parameter int CYC_200US = fpsc_pkg::CYC_200US,
    parameter int CYC_500US = fpsc_pkg::CYC_500US,
    parameter int CYC_1MS = fpsc_pkg::CYC_1MS,
    parameter int CYC_5MS = fpsc_pkg::CYC_5MS,
    parameter int CYC_10MS = fpsc_pkg::CYC_10MS,
    parameter int CYC_50MS = fpsc_pkg::CYC_50MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fpsc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic core_active_i,
    input wire logic all_idle_i,
    input wire logic [2:0] core_pstate_i,
    input wire logic gpu_high_i,
    input wire logic dma_active_i,
    input wire logic change_done_i,
    output logic change_req_o,
    output logic [6:0] fabric_clk_div_o,
    output logic [6:0] fabric_volt_code_o,
    output logic low_state_active_o,
    output logic transition_in_flight_o,
    output logic context_low_o
);
    localparam int CYC_120NS_OK = (fpsc_pkg::CYC_120NS > 0) ? 1 : 0;
    if (longint'(CYC_50MS) >= (longint'(1) << CW) || CYC_120NS_OK == 0) begin : g_bad_cw
        $error("timer width too small for the longest residency");
    end

    logic dis_ff, fsel_ff, freq_ff, lock_ff, ign_ff;
    logic [6:0] vid_ff, div_ff;
    logic [31:0] hi_ff;
    logic ovr_ff, csel_ff, seen_ff, state_ff, tgt_ff;
    logic force_pend_ff, p0_pend_ff;
    logic req, wr_lo, wr_hi, wr_ctl;
    logic [31:0] rd_lo, rd_hi, rd_ctl, wlo, rdata;
    logic busy, fin, start, nxt_tgt, hw_start, take_p0, take_frc;
    logic res_done, act_done, idle_done, hw_go, dma_blk;
    logic go_low, go_high;
    logic [6:0] div_in, vid_in;
    logic [CW-1:0] res_lim;

    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Residency codes: 0, 120 ns, 100 us .. 50 ms
    function automatic logic [CW-1:0] res_cyc(input logic [2:0] c);
        case (c)
            3'h0: return '0;
            3'h1: return CW'(fpsc_pkg::CYC_120NS);
            3'h2: return CW'(CYC_100US);
            3'h3: return CW'(CYC_500US);
            3'h4: return CW'(CYC_1MS);
            3'h5: return CW'(CYC_5MS);
            3'h6: return CW'(CYC_10MS);
            default: return CW'(CYC_50MS);
        endcase
    endfunction

    // Activity codes: 0, 120 ns, 25 us .. 1 ms
    function automatic logic [CW-1:0] act_cyc(input logic [2:0] c);
        case (c)
            3'h0: return '0;
            3'h1: return CW'(fpsc_pkg::CYC_120NS);
            3'h2: return CW'(fpsc_pkg::CYC_25US);
            3'h3: return CW'(fpsc_pkg::CYC_50US);
            3'h4: return CW'(CYC_100US);
            3'h5: return CW'(CYC_200US);
            3'h6: return CW'(CYC_500US);
            default: return CW'(CYC_1MS);
        endcase
    endfunction

    // Bus decode
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lo = req && wb_we_i && (wb_adr_i == fpsc_pkg::OFF_CFG_LO);
    assign wr_hi = req && wb_we_i && (wb_adr_i == fpsc_pkg::OFF_CFG_HI);
    assign wr_ctl = req && wb_we_i && (wb_adr_i == fpsc_pkg::OFF_CTL);

    assign rd_lo = {CAPABLE, dis_ff, fsel_ff, freq_ff, 7'h00, lock_ff, 3'h0, ign_ff,
                    1'b0, vid_ff, 1'b0, div_ff};
    assign rd_hi = hi_ff;
    assign rd_ctl = {ovr_ff, csel_ff, 27'h000_0000, state_ff, seen_ff, busy};
    assign wlo = be_merge(rd_lo, wb_dat_i, wb_sel_i);

    always_comb begin
        if (wb_adr_i == fpsc_pkg::OFF_CFG_LO) begin
            rdata = rd_lo;
        end else if (wb_adr_i == fpsc_pkg::OFF_CFG_HI) begin
            rdata = rd_hi;
        end else if (wb_adr_i == fpsc_pkg::OFF_CTL) begin
            rdata = rd_ctl;
        end else begin
            rdata = 32'h0000_0000;
        end
    end

    // Unmapped addresses still ack so a stray access cannot hang the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // Configuration low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dis_ff <= 1'b0;
            fsel_ff <= 1'b0;
            freq_ff <= 1'b0;
            lock_ff <= LOCK_RST;
            ign_ff <= 1'b0;
            vid_ff <= LO_VID_RST;
            div_ff <= LO_DIV_RST;
        end else if (ce_i && wr_lo) begin
            fsel_ff <= wlo[fpsc_pkg::B_FSEL];
            freq_ff <= wlo[fpsc_pkg::B_FREQ];
            ign_ff <= wlo[fpsc_pkg::B_IGN];
            lock_ff <= lock_ff | wlo[fpsc_pkg::B_LOCK];
            if (!lock_ff) begin
                dis_ff <= wlo[fpsc_pkg::B_DIS];
                vid_ff <= wlo[fpsc_pkg::L_VID +: 7];
                div_ff <= wlo[fpsc_pkg::L_DIV +: 7];
            end
        end
    end

    // Configuration high and control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_ff <= fpsc_pkg::CFG_HI_RST;
            ovr_ff <= fpsc_pkg::CTL_RST[fpsc_pkg::B_OVR];
            csel_ff <= fpsc_pkg::CTL_RST[fpsc_pkg::B_CSEL];
        end else if (ce_i) begin
            if (wr_hi) begin
                hi_ff <= be_merge(hi_ff, wb_dat_i, wb_sel_i) & fpsc_pkg::CFG_HI_MASK;
            end
            if (wr_ctl && wb_sel_i[3]) begin
                ovr_ff <= wb_dat_i[fpsc_pkg::B_OVR];
                csel_ff <= wb_dat_i[fpsc_pkg::B_CSEL];
            end
        end
    end

    // Write of one to the force bit is remembered until it can start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_pend_ff <= 1'b0;
            p0_pend_ff <= 1'b0;
        end else if (ce_i) begin
            if (wr_lo && wb_sel_i[3] && wb_dat_i[fpsc_pkg::B_FREQ]) begin
                force_pend_ff <= 1'b1;
            end else if (take_frc) begin
                force_pend_ff <= 1'b0;
            end
            if (wr_lo && !lock_ff && wb_sel_i[3] && wb_dat_i[fpsc_pkg::B_DIS] && !dis_ff) begin
                p0_pend_ff <= 1'b1;
            end else if (take_p0) begin
                p0_pend_ff <= 1'b0;
            end
        end
    end

    // Residency after a state change, then activity timers
    assign res_lim = state_ff ? res_cyc(hi_ff[fpsc_pkg::L_LRES +: 3])
                              : res_cyc(hi_ff[fpsc_pkg::L_HRES +: 3]);

    fpsc_timer #(.CW(CW)) u_res (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(!busy),
        .limit_i(res_lim),
        .done_o(res_done)
    );

    fpsc_timer #(.CW(CW)) u_act (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(core_active_i),
        .limit_i(act_cyc(hi_ff[fpsc_pkg::L_ACT +: 3])),
        .done_o(act_done)
    );

    fpsc_timer #(.CW(CW)) u_idle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(all_idle_i),
        .limit_i(act_cyc(hi_ff[fpsc_pkg::L_IDLE +: 3])),
        .done_o(idle_done)
    );

    // Lower P-state number means a faster core
    assign go_low = idle_done
        && (!hi_ff[fpsc_pkg::B_THREN] || core_pstate_i >= hi_ff[fpsc_pkg::L_THR +: 3])
        && (ign_ff || !gpu_high_i);
    assign go_high = act_done
        || (hi_ff[fpsc_pkg::B_THREN] && core_pstate_i < hi_ff[fpsc_pkg::L_THR +: 3])
        || (!ign_ff && gpu_high_i);
    assign dma_blk = hi_ff[fpsc_pkg::B_DMA] && dma_active_i;
    assign hw_go = !dis_ff && (state_ff ? go_high : go_low);

    // Start arbitration: return-to-0, forced, autonomous, divisor refresh
    always_comb begin
        start = 1'b0;
        nxt_tgt = state_ff;
        hw_start = 1'b0;
        take_p0 = 1'b0;
        take_frc = 1'b0;
        if (CAPABLE && !busy) begin
            if (p0_pend_ff) begin
                take_p0 = 1'b1;
                start = state_ff;
                nxt_tgt = 1'b0;
            end else if (force_pend_ff) begin
                take_frc = 1'b1;
                start = 1'b1;
                nxt_tgt = fsel_ff;
            end else if (hw_go && !dma_blk && res_done) begin
                hw_start = 1'b1;
                start = 1'b1;
                nxt_tgt = !state_ff;
            end else if (state_ff && div_ff != fabric_clk_div_o) begin
                start = 1'b1;
                nxt_tgt = 1'b1;
            end
        end
    end

    // Supply code taken from vid_ff only on a 0-to-1 entry; HI_VID on any move to state 0
    assign vid_in = !nxt_tgt ? HI_VID : (state_ff ? fabric_volt_code_o : vid_ff);
    assign div_in = nxt_tgt ? div_ff : HI_DIV;

    fpsc_apply #(.RST_DIV(HI_DIV), .RST_VID(HI_VID)) u_apply (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(start),
        .div_i(div_in),
        .vid_i(vid_in),
        .done_i(change_done_i),
        .div_o(fabric_clk_div_o),
        .vid_o(fabric_volt_code_o),
        .req_o(change_req_o),
        .busy_o(busy),
        .fin_o(fin)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgt_ff <= 1'b0;
            state_ff <= 1'b0;
        end else if (ce_i) begin
            if (start) begin
                tgt_ff <= nxt_tgt;
            end
            if (fin) begin
                state_ff <= tgt_ff;
            end
        end
    end

    // Entry set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_ff <= 1'b0;
        end else if (ce_i) begin
            if (fin && tgt_ff && !state_ff) begin
                seen_ff <= 1'b1;
            end else if (wr_ctl && wb_sel_i[0] && wb_dat_i[fpsc_pkg::B_SEEN]) begin
                seen_ff <= 1'b0;
            end
        end
    end

    assign low_state_active_o = state_ff;
    assign transition_in_flight_o = busy;
    assign context_low_o = ovr_ff ? csel_ff : state_ff;

    sequence s_low_entry;
        ce_i && start && nxt_tgt && !state_ff;
    endsequence
    sequence s_fin_low;
        fin && tgt_ff && !state_ff;
    endsequence

    AST_HW_DIS: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && dis_ff && !p0_pend_ff && !force_pend_ff && !busy
        && (!state_ff || div_ff == fabric_clk_div_o) |=> !busy)
        else $error("autonomous request while disabled");
    AST_P0_RETURN: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && CAPABLE && p0_pend_ff && !busy && state_ff |=> busy && !tgt_ff)
        else $error("disable did not return to state 0");
    AST_FORCE_TGT: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && CAPABLE && force_pend_ff && !p0_pend_ff && !busy |=> busy && tgt_ff == $past(fsel_ff))
        else $error("forced transition to wrong target");
    AST_FORCE_QUEUE: assert property (@(posedge clk_i) disable iff (rst_i)
        force_pend_ff && busy |=> force_pend_ff)
        else $error("queued forced request lost");
    AST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        lock_ff |=> lock_ff && $stable(dis_ff) && $stable(vid_ff) && $stable(div_ff))
        else $error("locked field changed");
    AST_GPU_IGN: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_start && !state_ff |-> ign_ff || !gpu_high_i)
        else $error("GPU activity ignored wrongly");
    AST_VID_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ce_i && start) |=> $stable(fabric_volt_code_o))
        else $error("supply code moved without a transition");
    AST_VID_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        s_low_entry |=> fabric_volt_code_o == $past(vid_ff))
        else $error("supply code not loaded on entry");
    AST_DIV_SWITCH: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && CAPABLE && state_ff && !busy && div_ff != fabric_clk_div_o |=> busy)
        else $error("divisor change not applied in state 1");
    AST_RESIDENCY: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_start |-> res_done)
        else $error("residency time not honoured");
    AST_DMA: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && dma_blk && !p0_pend_ff && !force_pend_ff && !busy
        && (!state_ff || div_ff == fabric_clk_div_o) |=> !busy)
        else $error("transition during blocking DMA");
    AST_THR: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_start && !state_ff && hi_ff[fpsc_pkg::B_THREN] |-> core_pstate_i >= hi_ff[fpsc_pkg::L_THR +: 3])
        else $error("core threshold not applied");
    AST_SEEN: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fin_low |=> seen_ff && state_ff)
        else $error("entry flag not set");
    AST_CTX: assert property (@(posedge clk_i) disable iff (rst_i)
        !ovr_ff |-> context_low_o == state_ff)
        else $error("context not following state");
endmodule

// ==== testbench/fpsc_partner.sv ====
// Purpose: Clock divider and regulator stand-in for the change link
// Assumes: Request held until done is seen
// Notes: Alternates quick and slow answers to stretch in-flight time
`timescale 1ns/1ps
module fpsc_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    output logic done_o
);
    logic done_ff;
    logic slow_ff;
    logic [4:0] cnt_ff;
    assign done_o = done_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_ff <= 1'b0;
            slow_ff <= 1'b0;
            cnt_ff <= 5'h00;
        end else begin
            done_ff <= 1'b0;
            // Done only once divisor and code both settled
            if (req_i && !done_ff) begin
                cnt_ff <= cnt_ff + 5'h01;
                if (cnt_ff == (slow_ff ? 5'h14 : 5'h01)) begin
                    done_ff <= 1'b1;
                    cnt_ff <= 5'h00;
                    slow_ff <= !slow_ff;
                end
            end
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the fabric performance state controller
// Assumes: Timer codes left at zero to keep the run short
// Notes: Software rules kept by the stimulus order
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, act = 1'b0, idle = 1'b0, dma = 1'b0;
    logic [7:0] adr = 8'h00;
    logic gpu = 1'b0;
    logic [2:0] pst = 3'h0;
    logic [31:0] dat = 32'h0000_0000, rdat, q;
    logic ack, req, done, low, infl, ctx;
    logic [6:0] div, volt;
    int mismatches = 0, comparisons = 0;
    always #10 clk_i = ~clk_i;
    fpsc_top fpsc_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .core_active_i(act), .all_idle_i(idle), .core_pstate_i(pst), .gpu_high_i(gpu),
        .dma_active_i(dma), .change_done_i(done), .change_req_o(req), .fabric_clk_div_o(div),
        .fabric_volt_code_o(volt), .low_state_active_o(low), .transition_in_flight_o(infl),
        .context_low_o(ctx));
    fpsc_partner fpsc_partner_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .done_o(done));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (ack !== 1'b1) begin
            mismatches++;
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    // Waits for one transition to open and close, then checks the state
    task go(input logic s);
        int n;
        n = 0;
        while (infl !== 1'b1 && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        while (infl !== 1'b0 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 500) begin
            mismatches++;
        end
        chk(32'(low), 32'(s));
    endtask
    task t_force;
        rdc(8'h90, 32'h8000_0002);
        rdc(8'h98, 32'h0000_0000);
        chk(32'(div), 32'h0000_0001);
        wb(1'b1, 8'h90, 32'h4000_0002);
        // New code and divisor only while disabled and before memory init
        wb(1'b1, 8'h90, 32'h4000_1505);
        // Ramp wait before the forced target changes
        repeat (20) @(posedge clk_i);
        wb(1'b1, 8'h90, 32'h7000_1505);
        go(1'b1);
        chk(32'(div), 32'h0000_0005);
        chk(32'(volt), 32'h0000_0015);
        rdc(8'h98, 32'h0000_0006);
        wb(1'b1, 8'h98, 32'h0000_0002);
        rdc(8'h98, 32'h0000_0004);
        wb(1'b1, 8'h90, 32'h5000_1505);
        wb(1'b1, 8'h90, 32'h7000_1505);
        go(1'b0);
        go(1'b1);
        // Divisor change in state 1; DRAM taken as held in self-refresh
        wb(1'b1, 8'h90, 32'h4000_1506);
        go(1'b1);
        chk(32'(div), 32'h0000_0006);
        chk(32'(volt), 32'h0000_0015);
        wb(1'b1, 8'h90, 32'h5000_1505);
        go(1'b0);
        chk(32'(volt), 32'h0000_0000);
        $display("test force done");
    endtask
    task t_auto;
        idle <= 1'b1;
        wb(1'b1, 8'h90, 32'h0000_1505);
        go(1'b1);
        {idle, act} <= 2'b01;
        go(1'b0);
        wb(1'b1, 8'h94, 32'h0000_0010);
        {idle, act, dma} <= 3'b101;
        repeat (100) @(posedge clk_i);
        chk(32'({low, infl}), 32'h0000_0000);
        dma <= 1'b0;
        go(1'b1);
        wb(1'b1, 8'h90, 32'h4000_1505);
        go(1'b0);
        repeat (100) @(posedge clk_i);
        chk(32'({low, infl}), 32'h0000_0000);
        $display("test autonomous done");
    endtask
    task t_gate;
        gpu <= 1'b1;
        wb(1'b1, 8'h90, 32'h0000_1505);
        repeat (50) @(posedge clk_i);
        chk(32'({low, infl}), 32'h0000_0000);
        wb(1'b1, 8'h90, 32'h0001_1505);
        go(1'b1);
        wb(1'b1, 8'h94, 32'h0000_000B);
        go(1'b0);
        repeat (50) @(posedge clk_i);
        chk(32'({low, infl}), 32'h0000_0000);
        pst <= 3'h3;
        go(1'b1);
        wb(1'b1, 8'h90, 32'h4001_1505);
        go(1'b0);
        $display("test gating done");
    endtask
    task t_lock;
        wb(1'b1, 8'h98, 32'hC000_0000);
        chk(32'(ctx), 32'h0000_0001);
        wb(1'b1, 8'h90, 32'h4010_1505);
        wb(1'b1, 8'h90, 32'h0000_0000);
        rdc(8'h90, 32'hC010_1505);
        $display("test lock done");
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_force();
        t_auto();
        t_gate();
        t_lock();
        conclude();
    end
endmodule
